// ### verif/interp_model.sv
`timescale 1ns/1ps
module interp_model #(
  parameter int DELAY = 1
) (
  input  wire logic ref_clk,           // System clock
  input  wire logic rst_n,             // Sync reset, low
  input  wire logic interp_start_edge, // Start edge from sequencer
  input  wire logic interp_stop_edge,  // Stop edge from sequencer
  output logic      start_coincidence, // Start coincidence pulse
  output logic      stop_coincidence   // Stop coincidence pulse
);
  // ----------------------------------------------------------------
  // Ramp stand-in
  // ----------------------------------------------------------------
  // A delay line replaces the ramp; a larger DELAY models a slow interpolator
  logic [DELAY-1:0] start_dly_r;
  logic [DELAY-1:0] stop_dly_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      start_dly_r <= '0;
      stop_dly_r  <= '0;
    end else begin
      start_dly_r <= (start_dly_r << 1) | DELAY'(interp_start_edge);
      stop_dly_r  <= (stop_dly_r << 1) | DELAY'(interp_stop_edge);
    end
  end

  assign start_coincidence = start_dly_r[DELAY-1];
  assign stop_coincidence  = stop_dly_r[DELAY-1];
endmodule

// ### verif/zero_dead_time_count_chain_tb.sv
`timescale 1ns/1ps
module zero_dead_time_count_chain_tb;
  localparam int AW = 2;
  logic          ref_clk, rst_n, chan_a, chan_b, reference_500m_clock, sequencer_reset, block_mode;
  logic          ext_arm, gate_in, start_coincidence, stop_coincidence, preset_we, rd_req, rd_ram;
  logic          rd_latch, rd_half, rd_data_oe, chain1_count_clock, chain2_count_clock, ram_write_pulse;
  logic          chain1_start_latch, chain1_stop_latch, chain2_start_latch, chain2_stop_latch;
  logic          interp_start_edge, interp_stop_edge, ram_block_done;
  logic [1:0]    clk_sel, ref_sel, tc_switch, rd_chain, terminal_count_flag;
  logic [2:0]    preset_sel;
  logic [15:0]   preset_data, rd_data;
  logic [AW-1:0] rd_addr, ram_addr;
  int            mismatches = 0, n_compared = 0;
  int            n_c1 = 0, n_c2 = 0, n_s1 = 0, n_p1 = 0, n_is = 0, n_ip = 0, n_wr = 0, n_s2 = 0, n_p2 = 0;

  zero_dead_time_count_chain #(.ADDR_W(AW)) i_dut (.ref_clk, .rst_n, .chan_a, .chan_b, .reference_500m_clock,
    .sequencer_reset, .block_mode, .clk_sel, .ref_sel, .tc_switch, .ext_arm, .gate_in, .start_coincidence,
    .stop_coincidence, .preset_we, .preset_sel, .preset_data, .rd_req, .rd_ram, .rd_chain, .rd_latch, .rd_half,
    .rd_addr, .rd_data, .rd_data_oe, .chain1_count_clock, .chain2_count_clock, .chain1_start_latch,
    .chain1_stop_latch, .chain2_start_latch, .chain2_stop_latch, .interp_start_edge, .interp_stop_edge,
    .terminal_count_flag, .ram_write_pulse, .ram_addr, .ram_block_done);

  interp_model #(.DELAY(1)) i_interp (.ref_clk, .rst_n, .interp_start_edge, .interp_stop_edge,
    .start_coincidence, .stop_coincidence);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Pulse counters, sampled mid-cycle where combinational pulses have settled
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (chain1_count_clock === 1'b1) n_c1++;
    if (chain2_count_clock === 1'b1) n_c2++;
    if (chain1_start_latch === 1'b1) n_s1++;
    if (chain1_stop_latch === 1'b1) n_p1++;
    if (interp_start_edge === 1'b1) n_is++;
    if (interp_stop_edge === 1'b1) n_ip++;
    if (ram_write_pulse === 1'b1) n_wr++;
    if (chain2_start_latch === 1'b1) n_s2++;
    if (chain2_stop_latch === 1'b1) n_p2++;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Each event is a one-cycle pulse followed by one idle cycle
  task automatic ev(input bit on_b);
    @(posedge ref_clk);
    if (on_b) chan_b <= 1'b1;
    else chan_a <= 1'b1;
    @(posedge ref_clk);
    chan_a <= 1'b0;
    chan_b <= 1'b0;
  endtask

  task automatic arm();
    @(posedge ref_clk);
    ext_arm <= 1'b1;
    @(posedge ref_clk);
    ext_arm <= 1'b0;
  endtask

  task automatic gate(input logic v);
    @(posedge ref_clk);
    gate_in <= v;
  endtask

  task automatic pre(input logic [2:0] sel, input logic [15:0] v);
    @(posedge ref_clk);
    preset_we <= 1'b1;
    preset_sel <= sel;
    preset_data <= v;
    @(posedge ref_clk);
    preset_we <= 1'b0;
  endtask

  task automatic rd(input logic ram, input logic [1:0] ch, input logic half, input logic [AW-1:0] a,
                    output logic [15:0] d);
    @(posedge ref_clk);
    rd_req <= 1'b1;
    rd_ram <= ram;
    rd_chain <= ch;
    rd_half <= half;
    rd_addr <= a;
    rd_latch <= a[0];
    @(posedge ref_clk);
    rd_req <= 1'b0;
    @(negedge ref_clk);
    check(rd_data_oe, 32'h1);
    d = rd_data;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_seq_reset();
    logic [15:0] d;
    int          c;
    @(posedge ref_clk);
    sequencer_reset <= 1'b1;
    pre(3'h0, 16'h00fe);
    pre(3'h1, 16'h0000);
    c = n_c1;
    arm();
    repeat (2) ev(0);
    check(n_c1 - c, 32'h0);
    rd(1'b0, 2'h0, 1'b0, '0, d);
    check(d, 32'h00fe);
    @(posedge ref_clk);
    rd_req <= 1'b1;
    rd_chain <= 2'h3;
    @(posedge ref_clk);
    rd_req <= 1'b0;
    @(negedge ref_clk);
    check(rd_data_oe, 32'h0);
  endtask

  task automatic s_count();
    logic [15:0] d;
    int          c1, c2;
    @(posedge ref_clk);
    sequencer_reset <= 1'b0;
    clk_sel <= 2'b10;
    arm();
    c1 = n_c1;
    c2 = n_c2;
    repeat (3) ev(0);
    repeat (2) ev(1);
    check(n_c1 - c1, 32'h3);
    check(n_c2 - c2, 32'h2);
    rd(1'b0, 2'h0, 1'b0, '0, d);
    check(d, 32'h0101);
    rd(1'b0, 2'h1, 1'b0, '0, d);
    check(d, 32'h0002);
  endtask

  task automatic s_cascade_tc();
    logic [15:0] d;
    int          c;
    pre(3'h0, 16'hffff);
    pre(3'h1, 16'h0012);
    ev(0);
    rd(1'b0, 2'h0, 1'b0, '0, d);
    check(d, 32'h0000);
    rd(1'b0, 2'h0, 1'b1, '0, d);
    check(d, 32'h0013);
    @(posedge ref_clk);
    tc_switch <= 2'b01;
    pre(3'h1, 16'hffff);
    pre(3'h0, 16'hfffe);
    @(negedge ref_clk);
    check(terminal_count_flag, 32'h0);
    ev(0);
    @(negedge ref_clk);
    check(terminal_count_flag, 32'h1);
    c = n_c1;
    ev(0);
    @(posedge ref_clk);
    reference_500m_clock <= 1'b1;
    @(posedge ref_clk);
    reference_500m_clock <= 1'b0;
    check(n_c1 - c, 32'h1);
  endtask

  // Start event plus three events, then the stop event eleven cycles after the start
  task automatic meas();
    int c[7];
    c = '{n_s1, n_is, n_p1, n_ip, n_wr, n_s2, n_p2};
    arm();
    gate(1'b1);
    step(2);
    repeat (4) ev(0);
    gate(1'b0);
    step(2);
    ev(0);
    step(8);
    check(n_s1 - c[0], 32'h1);
    check(n_is - c[1], 32'h1);
    check(n_p1 - c[2], 32'h1);
    check(n_ip - c[3], 32'h1);
    check(n_wr - c[4], 32'h2);
    check(n_s2 - c[5], 32'h1);
    check(n_p2 - c[6], 32'h1);
  endtask

  task automatic s_measure();
    logic [15:0] d0, d1;
    @(posedge ref_clk);
    sequencer_reset <= 1'b1;
    tc_switch <= 2'b00;
    ref_sel <= 2'b10;
    clk_sel <= 2'b00;
    block_mode <= 1'b1;
    reference_500m_clock <= 1'b1;
    @(posedge ref_clk);
    sequencer_reset <= 1'b0;
    meas();
    check(ram_addr, 32'h2);
    rd(1'b1, 2'h0, 1'b0, 2'h0, d0);
    rd(1'b1, 2'h0, 1'b0, 2'h1, d1);
    check(16'(d1 - d0), 32'h4);
    check(d0, 32'h0);
    rd(1'b0, 2'h0, 1'b0, 2'h1, d1);
    check(d1, 32'h4);
    rd(1'b1, 2'h1, 1'b0, 2'h0, d0);
    rd(1'b1, 2'h1, 1'b0, 2'h1, d1);
    check(16'(d1 - d0), 32'hb);
    rd(1'b1, 2'h2, 1'b0, 2'h0, d0);
    rd(1'b1, 2'h2, 1'b0, 2'h1, d1);
    check(16'(d1 - d0), 32'hb);
  endtask

  task automatic s_block_done();
    int cs, cw;
    meas();
    check(ram_block_done, 32'h1);
    cs = n_s1;
    cw = n_wr;
    arm();
    gate(1'b1);
    step(2);
    ev(0);
    step(4);
    check(n_s1 - cs, 32'h0);
    check(n_wr - cw, 32'h0);
  endtask

  initial begin
    {rst_n, chan_a, chan_b, reference_500m_clock, sequencer_reset, block_mode, ext_arm, gate_in} = '0;
    {preset_we, rd_req, rd_ram, rd_latch, rd_half, clk_sel, ref_sel, tc_switch, rd_chain, preset_sel} = '0;
    preset_data = 16'h0000;
    rd_addr = '0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_seq_reset();
    s_count();
    s_cascade_tc();
    s_measure();
    s_block_done();
    report_and_stop();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end
endmodule

// ### verilog/zdt_pkg.sv
package zdt_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int STAGE_W       = 8;
  localparam int WORD_W        = 16;
  localparam int CHAIN_W       = 32;
  localparam int NUM_CHAINS    = 3;
  localparam int TIMING_CHAIN  = 2;
  localparam int RAM_ADDR_W    = 8;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [15:0] WORD_RST  = 16'h0000;

  typedef enum logic [1:0] {
    WR_IDLE   = 2'b00,
    WR_LATCH1 = 2'b01,
    WR_LATCH2 = 2'b10
  } wr_state_type;

endpackage

// ### verilog/zero_dead_time_count_chain.sv
`timescale 1ns/1ps
module zero_dead_time_count_chain #(
  parameter int ADDR_W = zdt_pkg::RAM_ADDR_W
) (
  input  wire logic              ref_clk,              // System clock
  input  wire logic              rst_n,                // Sync reset, low
  input  wire logic              chan_a,               // Channel A event pulse
  input  wire logic              chan_b,               // Channel B event pulse
  input  wire logic              reference_500m_clock, // Reference tick
  input  wire logic              sequencer_reset,      // Holds sequencer idle
  input  wire logic              block_mode,           // Measurement size > 1
  input  wire logic [1:0]        clk_sel,              // Per chain: 0 A, 1 B
  input  wire logic [1:0]        ref_sel,              // Per chain: count reference
  input  wire logic [1:0]        tc_switch,            // Per chain: go to reference on TC
  input  wire logic              ext_arm,              // First arming stage pulse
  input  wire logic              gate_in,              // Gating level
  input  wire logic              start_coincidence,    // Start interpolator done
  input  wire logic              stop_coincidence,     // Stop interpolator done
  input  wire logic              preset_we,            // Preset strobe
  input  wire logic [2:0]        preset_sel,           // {chain, upper half}
  input  wire logic [15:0]       preset_data,          // Preset word
  input  wire logic              rd_req,               // Read strobe
  input  wire logic              rd_ram,               // Read RAM, not latch
  input  wire logic [1:0]        rd_chain,             // Chain select
  input  wire logic              rd_latch,             // Latch 1 or 2
  input  wire logic              rd_half,              // Upper word
  input  wire logic [ADDR_W-1:0] rd_addr,              // RAM address
  output logic [15:0]            rd_data,              // Read word
  output logic                   rd_data_oe,           // Bus drive enable
  output logic                   chain1_count_clock,   // Routed count pulse
  output logic                   chain2_count_clock,   // Routed count pulse
  output logic                   chain1_start_latch,   // Start latch pulse
  output logic                   chain1_stop_latch,    // Stop latch pulse
  output logic                   chain2_start_latch,   // Start latch pulse
  output logic                   chain2_stop_latch,    // Stop latch pulse
  output logic                   interp_start_edge,    // Start edge out
  output logic                   interp_stop_edge,     // Stop edge out
  output logic [1:0]             terminal_count_flag,  // Event chain TC
  output logic                   ram_write_pulse,      // RAM write strobe
  output logic [ADDR_W-1:0]      ram_addr,             // RAM address counter
  output logic                   ram_block_done        // Block done, data ready
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Each 8-bit stage counts when every lower stage wraps, as an all-ones
  // stage passes its carry on to the next.
  function automatic logic [31:0] advance(input logic [31:0] v);
    logic [31:0] r;
    logic        carry;
    r = v;
    carry = 1'b1;
    for (int s = 0; s < zdt_pkg::CHAIN_W / zdt_pkg::STAGE_W; s++) begin
      r[s*8 +: 8] = v[s*8 +: 8] + {7'h00, carry};
      carry = carry & (&v[s*8 +: 8]);
    end
    return r;
  endfunction

  function automatic logic [15:0] half_of(input logic [31:0] v, input logic hi);
    return hi ? v[31:16] : v[15:0];
  endfunction

  // ----------------------------------------------------------------
  // Routing and arming
  // ----------------------------------------------------------------
  logic [31:0]  cnt_r [zdt_pkg::NUM_CHAINS];
  logic [31:0]  lat_r [zdt_pkg::NUM_CHAINS][2];
  logic [1:0]   pend_r [zdt_pkg::NUM_CHAINS];
  logic [1:0]   cap_r;
  logic [1:0]   tc_seen_r;
  logic [1:0]   use_ref;
  logic [2:0]   tick;
  logic [1:0]   req [zdt_pkg::NUM_CHAINS];
  logic         arm1_r;
  logic         st_arm2_r;
  logic         sp_arm2_r;
  logic         st_done_r;
  logic         sp_done_r;
  logic         gate_q_r;
  logic         route_ok;
  logic         start_evt;
  logic         stop_evt;
  logic         meas_end;
  logic         wr_go;
  zdt_pkg::wr_state_type wr_state_r;

  assign route_ok = !sequencer_reset && !ram_block_done;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      use_ref[c] = ref_sel[c] | (tc_switch[c] & tc_seen_r[c]);
      tick[c] = 1'b0;
      if (!sequencer_reset && arm1_r) begin
        tick[c] = use_ref[c] ? reference_500m_clock : (clk_sel[c] ? chan_b : chan_a);
      end
    end
    tick[zdt_pkg::TIMING_CHAIN] = reference_500m_clock;
  end

  assign chain1_count_clock = tick[0];
  assign chain2_count_clock = tick[1];

  // Measured channel is whatever chain 1 is routed to
  assign start_evt = route_ok && st_arm2_r && tick[0];
  assign stop_evt  = route_ok && sp_arm2_r && tick[0];
  assign interp_start_edge = start_evt;
  assign interp_stop_edge  = stop_evt;

  // A chain counting the reference is latched by coincidence, so its
  // count lines up with the interpolator's residue.
  assign chain1_start_latch = use_ref[0] ? route_ok && start_coincidence : start_evt;
  assign chain1_stop_latch  = use_ref[0] ? route_ok && stop_coincidence  : stop_evt;
  assign chain2_start_latch = use_ref[1] ? route_ok && start_coincidence : start_evt;
  assign chain2_stop_latch  = use_ref[1] ? route_ok && stop_coincidence  : stop_evt;

  always_comb begin
    req[0] = {chain1_stop_latch, chain1_start_latch};
    req[1] = {chain2_stop_latch, chain2_start_latch};
    req[zdt_pkg::TIMING_CHAIN] = {stop_coincidence, start_coincidence};
  end

  always_ff @(posedge ref_clk) begin
    gate_q_r <= gate_in;
  end

  // Arming resets with the sequencer and at end of measurement; the counters keep their counts
  always_ff @(posedge ref_clk) begin
    if (!rst_n || sequencer_reset) begin
      arm1_r    <= 1'b0;
      st_arm2_r <= 1'b0;
      sp_arm2_r <= 1'b0;
      st_done_r <= 1'b0;
      sp_done_r <= 1'b0;
    end else begin
      // End of measurement clears arming; an arm pulse in that cycle still wins
      if (meas_end) begin
        {arm1_r, st_arm2_r, sp_arm2_r, st_done_r, sp_done_r} <= 5'h00;
      end
      if (ext_arm) begin
        arm1_r <= 1'b1;
      end
      if (arm1_r && gate_in && !gate_q_r && !st_done_r) begin
        st_arm2_r <= 1'b1;
      end else if (start_evt) begin
        st_arm2_r <= 1'b0;
      end
      if (start_evt) begin
        st_done_r <= 1'b1;
      end
      if (st_done_r && !gate_in && gate_q_r && !sp_done_r) begin
        sp_arm2_r <= 1'b1;
      end else if (stop_evt) begin
        sp_arm2_r <= 1'b0;
      end
      if (stop_evt) begin
        sp_done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (!rst_n || sequencer_reset) begin
        tc_seen_r[c] <= 1'b0;
      end else if (arm1_r && terminal_count_flag[c]) begin
        tc_seen_r[c] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters and latches
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < zdt_pkg::NUM_CHAINS; c++) begin
      if (!rst_n) begin
        cnt_r[c] <= zdt_pkg::COUNT_RST;
      end else if (preset_we && preset_sel[2:1] == 2'(c)) begin
        // Upper word preset too, so all-ones reaches the chain TC
        if (preset_sel[0]) begin
          cnt_r[c][31:16] <= preset_data;
        end else begin
          cnt_r[c][15:0] <= preset_data;
        end
      end else if (tick[c]) begin
        cnt_r[c] <= advance(cnt_r[c]);
      end
    end
  end

  // Requests wait for the next count clock, then freeze the count
  // that is present while counting carries on.
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < zdt_pkg::NUM_CHAINS; c++) begin
      for (int k = 0; k < 2; k++) begin
        if (!rst_n) begin
          pend_r[c][k] <= 1'b0;
          lat_r[c][k]  <= zdt_pkg::COUNT_RST;
        end else if (tick[c] && (pend_r[c][k] || req[c][k])) begin
          pend_r[c][k] <= 1'b0;
          lat_r[c][k]  <= cnt_r[c];
        end else if (req[c][k]) begin
          pend_r[c][k] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (!rst_n) begin
        cap_r[k] <= 1'b0;
      end else if (tick[0] && (pend_r[0][k] || req[0][k])) begin
        cap_r[k] <= 1'b1;
      end else if (meas_end) begin
        cap_r[k] <= 1'b0;
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      terminal_count_flag[c] = &cnt_r[c];
    end
  end

  // ----------------------------------------------------------------
  // RAM write train
  // ----------------------------------------------------------------
  logic [31:0] ram_r [zdt_pkg::NUM_CHAINS][2**ADDR_W];

  assign wr_go    = cap_r == 2'b11;
  assign meas_end = wr_state_r == zdt_pkg::WR_LATCH2;
  assign ram_write_pulse = wr_state_r != zdt_pkg::WR_IDLE;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_state_r <= zdt_pkg::WR_IDLE;
    end else begin
      case (wr_state_r)
        zdt_pkg::WR_IDLE: begin
          if (wr_go && !ram_block_done) begin
            wr_state_r <= zdt_pkg::WR_LATCH1;
          end
        end
        zdt_pkg::WR_LATCH1: begin
          wr_state_r <= zdt_pkg::WR_LATCH2;
        end
        default: begin
          wr_state_r <= zdt_pkg::WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ram_write_pulse) begin
      for (int c = 0; c < zdt_pkg::NUM_CHAINS; c++) begin
        ram_r[c][ram_addr] <= lat_r[c][meas_end];
      end
    end
  end

  // Done stays up until the sequencer is reset for a new block
  always_ff @(posedge ref_clk) begin
    if (!rst_n || sequencer_reset) begin
      ram_addr       <= '0;
      ram_block_done <= 1'b0;
    end else if (ram_write_pulse) begin
      ram_addr <= ram_addr + 1'b1;
      if (&ram_addr) begin
        ram_block_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data    <= zdt_pkg::WORD_RST;
      rd_data_oe <= 1'b0;
    end else begin
      rd_data_oe <= rd_req && rd_chain != 2'h3;
      if (rd_req && rd_chain != 2'h3) begin
        if (!block_mode) begin
          rd_data <= half_of(cnt_r[rd_chain], rd_half);
        end else if (rd_ram) begin
          rd_data <= half_of(ram_r[rd_chain][rd_addr], rd_half);
        end else begin
          rd_data <= half_of(lat_r[rd_chain][rd_latch], rd_half);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_gate_rise;
    arm1_r && gate_in && !gate_q_r && !st_done_r && !sequencer_reset && wr_state_r != zdt_pkg::WR_LATCH2;
  endsequence

  sequence s_wr_start;
    wr_state_r == zdt_pkg::WR_IDLE && wr_go && !ram_block_done;
  endsequence

  a_count_step: assert property (tick[0] && !preset_we |=> cnt_r[0] == $past(cnt_r[0]) + 32'h1)
    else $error("count did not advance by one");
  a_tc_reach: assert property (cnt_r[0] == 32'hffff_fffe && tick[0] && !preset_we |=> terminal_count_flag[0])
    else $error("terminal count missed");
  a_block_stops: assert property (ram_block_done |-> !chain1_start_latch && !interp_start_edge && !$rose(ram_write_pulse))
    else $error("activity after block done");
  a_write_train: assert property (s_wr_start |=> ram_write_pulse [*2] ##1 !ram_write_pulse)
    else $error("write train not two pulses");
  a_seq_quiet: assert property (sequencer_reset |-> tick[1:0] == 2'b00 && !interp_start_edge && !interp_stop_edge)
    else $error("sequencer active in reset");
  a_route_a: assert property (!sequencer_reset && arm1_r && !use_ref[0] && !clk_sel[0] |-> chain1_count_clock == chan_a)
    else $error("channel A not routed");
  a_second_stage: assert property (s_gate_rise |=> st_arm2_r)
    else $error("gate edge did not arm start");
  a_latch_freeze: assert property (tick[0] && chain1_start_latch |=> lat_r[0][0] == $past(cnt_r[0]))
    else $error("latched value wrong");
  a_read_live: assert property (rd_req && !block_mode && rd_chain == 2'h0 && !rd_half |=>
                                rd_data_oe && rd_data == $past(cnt_r[0][15:0]))
    else $error("live read wrong");
  a_coinc_latch: assert property (start_coincidence && use_ref[1] && route_ok && tick[1] |=>
                                  lat_r[1][0] == $past(cnt_r[1]))
    else $error("coincidence did not latch");

endmodule
